// file: hw/dsc_regs.sv
/*
  Status, command and device-control register bank of a storage device.
  Assumes the host strobes and register address come from pins and are
  synchronised here; the device core runs on clk and reports through
  core_i. The interrupt pin is tristated outside from host_interrupt_line_oe_b.
*/
`timescale 1ns/100ps
`include "dsc_defs.svh"
module dsc_regs (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              dev_id,
  input  wire logic              packet_mode,
  input  wire logic              overlap_en,
  input  wire dsc_pkg::dsc_hreq_t hreq_i,
  input  wire dsc_pkg::dsc_core_t core_i,
  output logic [7:0]             rdata_o,
  output logic                   cmd_go_o,
  output logic [7:0]             cmd_code_o,
  output logic                   host_interrupt_line_o,
  output logic                   host_interrupt_line_oe_b,
  output logic                   core_reset_o
);
  import dsc_pkg::*;

  // two-stage synchronisers for the pin group and the select strap
  dsc_hreq_t  req_s1_r, req_s2_r, req_s1_nxt, req_s2_nxt;
  logic       rd_d_r, wr_d_r, rd_d_nxt, wr_d_nxt;
  logic       dev_s1_r, dev_s2_r, dev_s1_nxt, dev_s2_nxt;

  always_comb begin
    req_s1_nxt = hreq_i;
    req_s2_nxt = req_s1_r;
    rd_d_nxt   = req_s2_r.rd;
    wr_d_nxt   = req_s2_r.wr;
    dev_s1_nxt = dev_id;
    dev_s2_nxt = dev_s1_r;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_s1_r <= '0;
      req_s2_r <= '0;
      rd_d_r   <= 1'b0;
      wr_d_r   <= 1'b0;
      dev_s1_r <= 1'b0;
      dev_s2_r <= 1'b0;
    end else begin
      req_s1_r <= req_s1_nxt;
      req_s2_r <= req_s2_nxt;
      rd_d_r   <= rd_d_nxt;
      wr_d_r   <= wr_d_nxt;
      dev_s1_r <= dev_s1_nxt;
      dev_s2_r <= dev_s2_nxt;
    end
  end

  // act once per strobe, on the rising edge of the synchronised level
  logic rd_pulse, wr_pulse, cmd_sel, ctl_sel;
  logic st_rd, alt_rd, st_wr, ctl_wr, sel_wr, err_rd;
  assign rd_pulse = req_s2_r.rd & ~rd_d_r;
  assign wr_pulse = req_s2_r.wr & ~wr_d_r;
  assign cmd_sel  = (req_s2_r.cs == `DSC_CS_CMD);
  assign ctl_sel  = (req_s2_r.cs == `DSC_CS_CTL);
  assign st_rd    = rd_pulse & cmd_sel & (req_s2_r.da == `DSC_DA_STATUS);
  assign err_rd   = rd_pulse & cmd_sel & (req_s2_r.da == `DSC_DA_ERROR);
  assign alt_rd   = rd_pulse & ctl_sel & (req_s2_r.da == `DSC_DA_ALTCTL);
  assign st_wr    = wr_pulse & cmd_sel & (req_s2_r.da == `DSC_DA_STATUS);
  assign sel_wr   = wr_pulse & cmd_sel & (req_s2_r.da == `DSC_DA_SELECT);
  assign ctl_wr   = wr_pulse & ctl_sel & (req_s2_r.da == `DSC_DA_ALTCTL);

  // main state and register set
  dsc_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt, drq_r, drq_nxt;
  logic ready_r, ready_nxt, ready_lock_r, ready_lock_nxt;
  logic fault_r, fault_nxt, seek_r, seek_nxt, seek_hold_r, seek_hold_nxt;
  logic corrected_error_flag_r, corrected_error_flag_nxt, index_r, index_nxt, err_r, err_nxt;
  logic service_r, service_nxt, dmardy_r, dmardy_nxt;
  logic soft_reset_bit_r, soft_reset_bit_nxt, interrupt_disable_bit_r, interrupt_disable_bit_nxt, pend_r, pend_nxt;
  logic [7:0] error_r, error_nxt, select_r, select_nxt;
  logic [7:0] cmd_r, cmd_nxt, rdata_nxt;
  logic go_r, go_nxt, host_interrupt_line_nxt, oe_b_nxt, crst_nxt;
  logic [7:0] status;
  logic selected;

  // status image; packet devices reuse bits 5 and 4 when overlap_en is set, and read bit 1 as zero
  always_comb begin
    status = `DSC_STATUS_RST;
    status[`DSC_ST_BUSY]  = busy_r;
    status[`DSC_ST_READY] = ready_r;
    status[`DSC_ST_DREQ]  = drq_r;
    status[`DSC_ST_CORRECTED_ERROR_FLAG]  = corrected_error_flag_r;
    status[`DSC_ST_ERR]   = err_r;
    if (packet_mode) begin
      status[`DSC_ST_FAULT] = overlap_en ? dmardy_r : fault_r;
      status[`DSC_ST_SEEK]  = overlap_en ? service_r : seek_r;
    end else begin
      status[`DSC_ST_FAULT] = fault_r;
      status[`DSC_ST_SEEK]  = seek_r;
      status[`DSC_ST_INDEX] = index_r;
    end
  end

  assign selected = (select_nxt[`DSC_SEL_DEV] == dev_s2_r);

  always_comb begin
    state_nxt      = state_r;
    cnt_nxt        = cnt_r;
    busy_nxt       = busy_r;
    drq_nxt        = drq_r;
    ready_nxt      = ready_r;
    ready_lock_nxt = ready_lock_r;
    // level flags track the core every cycle, busy or not
    fault_nxt      = core_i.fault;
    index_nxt      = core_i.index;
    seek_hold_nxt  = seek_hold_r;
    seek_nxt       = seek_r;
    corrected_error_flag_nxt       = corrected_error_flag_r;
    err_nxt        = err_r;
    service_nxt    = service_r;
    dmardy_nxt     = core_i.dma_ready;
    soft_reset_bit_nxt       = soft_reset_bit_r;
    interrupt_disable_bit_nxt       = interrupt_disable_bit_r;
    pend_nxt       = pend_r;
    error_nxt      = error_r;
    select_nxt     = select_r;
    cmd_nxt        = cmd_r;
    go_nxt         = 1'b0;
    rdata_nxt      = rdata_o;
    // control register is writable at any time, reserved bits dropped
    if (ctl_wr) begin
      soft_reset_bit_nxt = req_s2_r.wdata[`DSC_CT_SOFT_RESET_BIT];
      interrupt_disable_bit_nxt = req_s2_r.wdata[`DSC_CT_INTERRUPT_DISABLE_BIT];
    end
    // read data capture
    if (rd_pulse) begin
      if (st_rd || alt_rd)
        rdata_nxt = status;
      else if (err_rd)
        rdata_nxt = error_r;
      else if (cmd_sel && req_s2_r.da == `DSC_DA_SELECT)
        rdata_nxt = select_r;
      else
        rdata_nxt = 8'h00;
    end
    // ready lock and seek hold both release on a primary status read
    if (st_rd) begin
      ready_lock_nxt = 1'b0;
      seek_hold_nxt  = 1'b0;
    end
    if (!seek_hold_r && !st_rd)
      seek_nxt = core_i.seek_done;
    // low from a power-on reset through the reset state and the first idle cycle
    // ready may rise once the lock is free; idle modes keep it high
    if (!ready_lock_r && !ready_r && state_r != DSC_RESET) begin
      ready_nxt      = 1'b1;
      ready_lock_nxt = 1'b1;
    end
    if (core_i.corrected_error_flag)
      corrected_error_flag_nxt = 1'b1;
    if (core_i.service_req)
      service_nxt = 1'b1;
    // select register writes only when busy, data request and error are all low
    if (sel_wr && !busy_r && !drq_r && !err_r)
      select_nxt = req_s2_r.wdata;
    // interrupt pending: a new event wins over a primary status read clear in the same cycle
    if (st_rd)
      pend_nxt = 1'b0;
    case (state_r)
      DSC_RESET: begin
        busy_nxt = 1'b1;
        drq_nxt  = 1'b0;
        if (soft_reset_bit_r)
          cnt_nxt = 4'h0;
        else if (cnt_r != 4'(`DSC_RESET_CYC))
          cnt_nxt = cnt_r + 4'h1;
        else begin
          busy_nxt  = 1'b0;
          state_nxt = DSC_IDLE;
        end
      end
      DSC_IDLE: begin
        if (st_wr && !busy_r) begin
          cmd_nxt   = req_s2_r.wdata;
          go_nxt    = 1'b1;
          busy_nxt  = 1'b1;
          err_nxt   = 1'b0;
          // a corrected or service event in this cycle beats the clear
          corrected_error_flag_nxt  = core_i.corrected_error_flag;
          state_nxt = DSC_ACCEPT;
          if (req_s2_r.wdata == `DSC_CMD_SERVICE)
            service_nxt = core_i.service_req;
          if (!ready_r && req_s2_r.wdata != `DSC_CMD_DIAG &&
              req_s2_r.wdata != `DSC_CMD_INITP)
            state_nxt = DSC_EXEC;
        end
      end
      DSC_ACCEPT: begin
        // one cycle for the core to see the go pulse
        state_nxt = DSC_XFER;
      end
      DSC_EXEC: begin
        // command refused while not ready
        error_nxt = 8'h00;
        error_nxt[`DSC_ER_ABORT] = 1'b1;
        err_nxt   = 1'b1;
        seek_hold_nxt = 1'b1;
        busy_nxt  = 1'b0;
        pend_nxt  = 1'b1;
        state_nxt = DSC_IDLE;
      end
      DSC_XFER: begin
        if (core_i.done) begin
          busy_nxt  = 1'b0;
          drq_nxt   = 1'b0;
          pend_nxt  = 1'b1;
          state_nxt = DSC_IDLE;
          if (core_i.done_err) begin
            err_nxt       = 1'b1;
            error_nxt     = core_i.done_error;
            seek_hold_nxt = 1'b1;
          end
        end else if (busy_r) begin
          // while busy, data request follows the core's request
          drq_nxt  = core_i.xfer_drq;
          busy_nxt = core_i.xfer_busy | ~core_i.xfer_drq;
        end else if (drq_r && !core_i.xfer_drq) begin
          // between blocks busy takes over from the request
          busy_nxt = core_i.xfer_busy;
          drq_nxt  = ~core_i.xfer_busy;
        end
      end
      default: state_nxt = DSC_RESET;
    endcase
    // soft reset wins over every state while the bit stands
    if (soft_reset_bit_nxt) begin
      state_nxt     = DSC_RESET;
      busy_nxt      = 1'b1;
      drq_nxt       = 1'b0;
      err_nxt       = 1'b0;
      seek_hold_nxt = 1'b0;
      error_nxt     = `DSC_ERROR_RST;
      pend_nxt      = 1'b0;
      cnt_nxt       = 4'h0;
    end
    // idle: nothing else moves except allowed flags
    if (state_r == DSC_IDLE && !st_wr)
      drq_nxt = drq_r;
  end

  // pin outputs from flops
  always_comb begin
    host_interrupt_line_nxt = pend_nxt;
    oe_b_nxt  = ~(~interrupt_disable_bit_nxt & selected);
    crst_nxt  = (state_nxt == DSC_RESET);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r      <= DSC_RESET;
      cnt_r        <= 4'h0;
      busy_r       <= 1'b1;
      drq_r        <= 1'b0;
      ready_r      <= 1'b0;
      ready_lock_r <= 1'b0;
      fault_r      <= 1'b0;
      seek_r       <= 1'b0;
      seek_hold_r  <= 1'b0;
      corrected_error_flag_r       <= 1'b0;
      index_r      <= 1'b0;
      err_r        <= 1'b0;
      service_r    <= 1'b0;
      dmardy_r     <= 1'b0;
      soft_reset_bit_r       <= 1'b0;
      interrupt_disable_bit_r       <= 1'b0;
      pend_r       <= 1'b0;
      error_r      <= `DSC_ERROR_RST;
      select_r     <= `DSC_SELECT_RST;
      cmd_r        <= 8'h00;
      go_r         <= 1'b0;
      rdata_o      <= 8'h00;
      host_interrupt_line_o      <= 1'b0;
      host_interrupt_line_oe_b   <= 1'b1;
      core_reset_o <= 1'b1;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      busy_r       <= busy_nxt;
      drq_r        <= drq_nxt;
      ready_r      <= ready_nxt;
      ready_lock_r <= ready_lock_nxt;
      fault_r      <= fault_nxt;
      seek_r       <= seek_nxt;
      seek_hold_r  <= seek_hold_nxt;
      corrected_error_flag_r       <= corrected_error_flag_nxt;
      index_r      <= index_nxt;
      err_r        <= err_nxt;
      service_r    <= service_nxt;
      dmardy_r     <= dmardy_nxt;
      soft_reset_bit_r       <= soft_reset_bit_nxt;
      interrupt_disable_bit_r       <= interrupt_disable_bit_nxt;
      pend_r       <= pend_nxt;
      error_r      <= error_nxt;
      select_r     <= select_nxt;
      cmd_r        <= cmd_nxt;
      go_r         <= go_nxt;
      rdata_o      <= rdata_nxt;
      host_interrupt_line_o      <= host_interrupt_line_nxt;
      host_interrupt_line_oe_b   <= oe_b_nxt;
      core_reset_o <= crst_nxt;
    end
  end

  assign cmd_go_o   = go_r;
  assign cmd_code_o = cmd_r;
endmodule : dsc_regs

// file: common/dsc_defs.svh
/*
  Constants for the disk status and control register block.
  Assumes inclusion by bare name from the design and its package.
*/
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH
// register addresses: chip-select pair and 3-bit device address
`define DSC_CS_CMD        2'h2
`define DSC_CS_CTL        2'h1
`define DSC_DA_ERROR      3'h1
`define DSC_DA_SELECT     3'h6
`define DSC_DA_STATUS     3'h7
`define DSC_DA_ALTCTL     3'h6
// status bit positions
`define DSC_ST_BUSY       7
`define DSC_ST_READY      6
`define DSC_ST_FAULT      5
`define DSC_ST_SEEK       4
`define DSC_ST_DREQ       3
`define DSC_ST_CORRECTED_ERROR_FLAG       2
`define DSC_ST_INDEX      1
`define DSC_ST_ERR        0
// device control bit positions
`define DSC_CT_SOFT_RESET_BIT       2
`define DSC_CT_INTERRUPT_DISABLE_BIT       1
// select register drive bit
`define DSC_SEL_DEV       4
// error register abort bit
`define DSC_ER_ABORT      2
// command codes
`define DSC_CMD_SERVICE   8'hA2
`define DSC_CMD_DIAG      8'h90
`define DSC_CMD_INITP     8'h91
// reset values
`define DSC_STATUS_RST    8'h00
`define DSC_ERROR_RST     8'h01
`define DSC_SELECT_RST    8'h00
// timing: busy must rise within this time
`define DSC_BUSY_NS       400
`define DSC_CLK_NS        40
`define DSC_BUSY_CYC      (`DSC_BUSY_NS / `DSC_CLK_NS)
`define DSC_RESET_CYC     8
`endif

// file: common/dsc_pkg.sv
/*
  Types for the disk status and control register block.
  Assumes the defs header is on the include path.
*/
`include "dsc_defs.svh"
package dsc_pkg;
  // host register cycle, sampled on the device clock
  typedef struct packed {
    logic [1:0] cs;
    logic [2:0] da;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } dsc_hreq_t;
  // device core events and condition levels
  typedef struct packed {
    logic       index;
    logic       fault;
    logic       seek_done;
    logic       corrected_error_flag;
    logic       dma_ready;
    logic       service_req;
    logic       xfer_busy;
    logic       xfer_drq;
    logic       done;
    logic       done_err;
    logic [7:0] done_error;
  } dsc_core_t;
  typedef enum logic [2:0] {
    DSC_RESET, DSC_IDLE, DSC_ACCEPT, DSC_EXEC, DSC_XFER
  } dsc_state_t;
endpackage : dsc_pkg

// file: testbench/dsc_regs_props.sv
/*
  Checker for the disk status and control register block.
  Assumes it is bound to dsc_regs and sees only its ports.
*/
`timescale 1ns/100ps
module dsc_regs_chk (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               dev_id,
  input wire dsc_pkg::dsc_hreq_t hreq_i,
  input wire logic [7:0]         rdata_o,
  input wire logic               cmd_go_o,
  input wire logic [7:0]         cmd_code_o,
  input wire logic               host_interrupt_line_o,
  input wire logic               host_interrupt_line_oe_b,
  input wire logic               core_reset_o
);
  import dsc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // strobes are synchronised, so causes sit two clocks back
  reset_busy_a: assert property (!$past(rst_b) |-> core_reset_o [*6])
    else $error("reset state left too early");
  go_pulse_a: assert property (cmd_go_o |=> !cmd_go_o [*2])
    else $error("accept pulse too long");
  go_cause_a: assert property (cmd_go_o |-> $past(hreq_i.wr, 2)
    && $past(hreq_i.cs, 2) == 2'h2 && $past(hreq_i.da, 2) == 3'h7)
    else $error("accept without status write");
  go_in_reset_a: assert property (core_reset_o |-> !cmd_go_o)
    else $error("command taken in reset");
  code_hold_a: assert property ($changed(cmd_code_o) |-> cmd_go_o)
    else $error("command code moved alone");
  rdata_cause_a: assert property ($changed(rdata_o) |-> $past(hreq_i.rd, 2))
    else $error("read data moved without read");
  host_interrupt_line_clear_a: assert property ($fell(host_interrupt_line_o) |-> core_reset_o || $past(core_reset_o)
    || ($past(hreq_i.rd, 2) && $past(hreq_i.cs, 2) == 2'h2))
    else $error("interrupt cleared without status read");
  oe_cause_a: assert property ($changed(host_interrupt_line_oe_b) |-> $past(hreq_i.wr, 2)
    || $past(dev_id, 3) != $past(dev_id, 4) || core_reset_o || $past(core_reset_o))
    else $error("interrupt enable moved without cause");
endmodule : dsc_regs_chk

bind dsc_regs dsc_regs_chk i_chk (.clk(clk), .rst_b(rst_b), .dev_id(dev_id),
  .hreq_i(hreq_i), .rdata_o(rdata_o), .cmd_go_o(cmd_go_o), .cmd_code_o(cmd_code_o),
  .host_interrupt_line_o(host_interrupt_line_o), .host_interrupt_line_oe_b(host_interrupt_line_oe_b), .core_reset_o(core_reset_o));

// file: testbench/dsc_host.sv
/*
  Host model for the register pins of the disk status block.
  Assumes a free-running device clock; strobes are changed at falling edges.
*/
`timescale 1ns/100ps
module dsc_host (
  clk,
  rdata,
  hreq
);
  import dsc_pkg::*;
  input  wire logic [7:0] rdata;
  input  wire logic       clk;
  output dsc_hreq_t       hreq;
  initial hreq = '0;
  // strobe held 5 clocks, then 4 idle clocks for the synchroniser
  task automatic cyc(input logic [1:0] cs, input logic [2:0] da, input logic w,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    hreq.cs = cs;
    hreq.da = da;
    hreq.wdata = d;
    hreq.rd = !w;
    hreq.wr = w;
    repeat (5) @(negedge clk);
    q = rdata;
    hreq.rd = 1'b0;
    hreq.wr = 1'b0;
    hreq.wdata = ~d; // released bus must not show the old byte
    hreq.cs = 2'h0;
    repeat (4) @(negedge clk);
  endtask : cyc
  // control write: reserved bits and bit 0 always zero
  task automatic ctl(input logic soft_reset_bit, input logic interrupt_disable_bit);
    logic [7:0] q;
    cyc(2'h1, 3'h6, 1'b1, {5'h00, soft_reset_bit, interrupt_disable_bit, 1'b0}, q);
  endtask : ctl
endmodule : dsc_host

// file: testbench/dsc_regs_tb.sv
/*
  Self-checking bench for the disk status and control register block.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
`include "dsc_defs.svh"
module dsc_regs_tb;
  import dsc_pkg::*;
  logic       clk, rst_b, dev_id, packet_mode, overlap_en;
  dsc_hreq_t  hreq;
  dsc_core_t  core;
  logic [7:0] rdata, code, q;
  logic       go, host_interrupt_line, oe_b, creset;
  int         fails, samples_checked, gos, cycles;
  dsc_regs i_dut (.clk(clk), .rst_b(rst_b), .dev_id(dev_id), .packet_mode(packet_mode),
    .overlap_en(overlap_en), .hreq_i(hreq), .core_i(core), .rdata_o(rdata),
    .cmd_go_o(go), .cmd_code_o(code), .host_interrupt_line_o(host_interrupt_line), .host_interrupt_line_oe_b(oe_b),
    .core_reset_o(creset));
  dsc_host i_host (.clk(clk), .rdata(rdata), .hreq(hreq));
  always #20 clk = ~clk;
  // accept counter and hang guard
  always @(posedge clk) begin
    gos += int'(go);
    cycles++;
    if (cycles == 6000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic st(); i_host.cyc(2'h2, 3'h7, 1'b0, 8'h00, q); endtask : st
  task automatic cmd(input logic [7:0] c); i_host.cyc(2'h2, 3'h7, 1'b1, c, q); endtask : cmd
  // one-cycle completion report from the core
  task automatic finish_core(input logic e, input logic [7:0] er);
    @(negedge clk);
    core.done = 1'b1;
    core.done_err = e;
    core.done_error = er;
    @(negedge clk);
    core.done = 1'b0;
    repeat (2) @(negedge clk);
  endtask : finish_core
  task automatic t_reset();
    st();
    chk({7'h00, q[7]}, 8'h01);
    repeat (20) @(negedge clk);
    st();
    chk(q & 8'hC9, 8'h40);
  endtask : t_reset
  task automatic t_gate();
    i_host.ctl(1'b0, 1'b1);
    chk({7'h00, oe_b}, 8'h01);
    i_host.ctl(1'b0, 1'b0);
    chk({7'h00, oe_b}, 8'h00);
    i_host.cyc(2'h2, 3'h6, 1'b1, 8'h10, q);
    chk({7'h00, oe_b}, 8'h01);
    dev_id = 1'b1;
    repeat (4) @(negedge clk);
    chk({7'h00, oe_b}, 8'h00);
  endtask : t_gate
  task automatic t_command();
    cmd(8'h90);
    chk(8'(gos), 8'h01);
    chk(code, 8'h90);
    st();
    chk(q & 8'h88, 8'h80);
    cmd(8'h91);
    chk(8'(gos), 8'h01);
    core.xfer_drq = 1'b1;
    st();
    chk(q & 8'h88, 8'h08);
    core.xfer_drq = 1'b0;
    core.xfer_busy = 1'b1;
    st();
    chk(q & 8'h88, 8'h80);
    core.corrected_error_flag = 1'b1;
    core.xfer_busy = 1'b0;
    @(negedge clk);
    core.corrected_error_flag = 1'b0;
    st();
    chk(q & 8'h84, 8'h84);
    finish_core(1'b1, 8'h10);
    core.seek_done = 1'b1;
    chk({7'h00, host_interrupt_line}, 8'h01);
    i_host.cyc(2'h1, 3'h6, 1'b0, 8'h00, q);
    chk(q & 8'hC9, 8'h41);
    chk(q & 8'h10, 8'h00);
    chk({7'h00, host_interrupt_line}, 8'h01);
    st();
    chk({7'h00, host_interrupt_line}, 8'h00);
    i_host.cyc(2'h2, 3'h1, 1'b0, 8'h00, q);
    chk(q, 8'h10);
    i_host.cyc(2'h2, 3'h6, 1'b1, 8'h00, q);
    chk({7'h00, oe_b}, 8'h00);
    st();
    chk(q & 8'h10, 8'h10);
  endtask : t_command
  task automatic t_soft();
    i_host.ctl(1'b1, 1'b0);
    repeat (30) @(negedge clk);
    chk({7'h00, creset}, 8'h01);
    st();
    chk({7'h00, q[7]}, 8'h01);
    i_host.ctl(1'b0, 1'b0);
    repeat (20) @(negedge clk);
    chk({7'h00, creset}, 8'h00);
    i_host.cyc(2'h2, 3'h1, 1'b0, 8'h00, q);
    chk(q, 8'h01);
  endtask : t_soft
  task automatic t_packet();
    packet_mode = 1'b1;
    overlap_en = 1'b1;
    core.dma_ready = 1'b1;
    st();
    chk(q & 8'h20, 8'h20);
    overlap_en = 1'b0;
    core.dma_ready = 1'b0;
    core.fault = 1'b1;
    st();
    chk(q & 8'h20, 8'h20);
    core.fault = 1'b0;
    overlap_en = 1'b1;
    core.service_req = 1'b1;
    @(negedge clk);
    core.service_req = 1'b0;
    st();
    chk(q & 8'h10, 8'h10);
    cmd(8'hA2);
    finish_core(1'b0, 8'h00);
    st();
    chk(q & 8'h11, 8'h00);
  endtask : t_packet
  // second hardware reset; a command lands in the first idle cycle, not ready yet
  task automatic t_notready();
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
    cmd(8'h20);
    chk({7'h00, host_interrupt_line}, 8'h01);
    i_host.cyc(2'h2, 3'h1, 1'b0, 8'h00, q);
    chk(q, 8'h04);
    st();
    chk(q & 8'hC9, 8'h41);
  endtask : t_notready
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    dev_id = 1'b0;
    packet_mode = 1'b0;
    overlap_en = 1'b0;
    core = '0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_gate();
    t_command();
    t_soft();
    t_packet();
    t_notready();
    tally_and_finish();
  end
endmodule : dsc_regs_tb
